// *** sowd_pin_route.v ***
// routes the second serial unit and the two-wire unit onto port pins
`timescale 1ns/1ps
`default_nettype none
`include "sowd_regs.vh"
module sowd_pin_route (
  input  wire       i_sys_clk,
  input  wire       i_arst_n,
  input  wire       i_clk_en,
  input  wire       i_ser2_route,  // 0 = port f, 1 = port e
  input  wire       i_two_route,   // 0 = port f, 1 = port e
  input  wire       i_ser2_tx,     // serial transmit level from the unit
  input  wire       i_scl_low,     // two-wire unit pulls clock low
  input  wire       i_sda_low,     // two-wire unit pulls data low
  input  wire [3:0] i_port_f_in,
  input  wire [7:4] i_port_e_in,
  output reg  [3:0] o_port_f_out,
  output reg  [3:0] o_port_f_oe,
  output reg  [7:4] o_port_e_out,
  output reg  [7:4] o_port_e_oe,
  output reg        o_ser2_rx,
  output reg        o_scl_in,
  output reg        o_sda_in
);
  reg [3:0] next_f_out;
  reg [3:0] next_f_oe;
  reg [7:4] next_e_out;
  reg [7:4] next_e_oe;

  // pin selection; two-wire pins are open drain so their level is low
  always @* begin
    next_f_out = 4'h0;
    next_f_oe  = 4'h0;
    next_e_out = 4'h0;
    next_e_oe  = 4'h0;
    if (!i_ser2_route) begin                                      // [RULE_09]
      next_f_out[`SOWD_PF_TX] = i_ser2_tx;
      next_f_oe[`SOWD_PF_TX]  = 1'b1;
    end else begin
      next_e_out[`SOWD_PE_TX] = i_ser2_tx;
      next_e_oe[`SOWD_PE_TX]  = 1'b1;
    end
    if (!i_two_route) begin                                       // [RULE_10]
      next_f_oe[`SOWD_PF_SCL] = i_scl_low;
      next_f_oe[`SOWD_PF_SDA] = i_sda_low;
    end else begin
      next_e_oe[`SOWD_PE_SCL] = i_scl_low;
      next_e_oe[`SOWD_PE_SDA] = i_sda_low;
    end
  end

  // registered pin drive and returned input levels
  always @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_port_f_out <= 4'h0;
      o_port_f_oe  <= 4'h0;
      o_port_e_out <= 4'h0;
      o_port_e_oe  <= 4'h0;
      o_ser2_rx    <= 1'b1;
      o_scl_in     <= 1'b1;
      o_sda_in     <= 1'b1;
    end else if (i_clk_en) begin
      o_port_f_out <= next_f_out;
      o_port_f_oe  <= next_f_oe;
      o_port_e_out <= next_e_out;
      o_port_e_oe  <= next_e_oe;
      o_ser2_rx <= i_ser2_route ? i_port_e_in[`SOWD_PE_RX]
                                : i_port_f_in[`SOWD_PF_RX];       // [RULE_09]
      o_scl_in  <= i_two_route ? i_port_e_in[`SOWD_PE_SCL]
                               : i_port_f_in[`SOWD_PF_SCL];       // [RULE_10]
      o_sda_in  <= i_two_route ? i_port_e_in[`SOWD_PE_SDA]
                               : i_port_f_in[`SOWD_PF_SDA];       // [RULE_10]
    end
  end
endmodule // sowd_pin_route
`default_nettype wire

// *** sowd_regs.vh ***
// register map, field positions and timing constants of the options block
`ifndef SOWD_REGS_VH
`define SOWD_REGS_VH

// register port geometry
`define SOWD_ADDR_W       3
`define SOWD_DATA_W       8

// register offsets
`define SOWD_OFS_OPT1     3'h0
`define SOWD_OFS_OPT2     3'h1
`define SOWD_OFS_WDCLR    3'h2
`define SOWD_OFS_STAT     3'h3

// reset values and writable masks
`define SOWD_OPT1_RST     8'hc0
`define SOWD_OPT1_MASK    8'hf8
`define SOWD_OPT2_RST     8'h00
`define SOWD_OPT2_MASK    8'h03
`define SOWD_ZERO_BYTE    8'h00

// system_options_one fields
`define SOWD_TSEL_HI      7
`define SOWD_TSEL_LO      6
`define SOWD_STOPA_BIT    5
`define SOWD_SER2_BIT     4
`define SOWD_TWO_BIT      3

// system_options_two fields
`define SOWD_CLKSEL_BIT   0
`define SOWD_WINEN_BIT    1

// status fields
`define SOWD_ST_LOCK      0
`define SOWD_ST_RUN       1
`define SOWD_ST_WIN       2

// watchdog timeout select codes
`define SOWD_TSEL_OFF     2'h0
`define SOWD_TSEL_T1      2'h1
`define SOWD_TSEL_T2      2'h2
`define SOWD_TSEL_T3      2'h3

// low-power tick timeouts, in milliseconds (1.024 s for the longest)
`define SOWD_US_PER_MS    1000
`define SOWD_LPO_PERIOD_US 1000
`define SOWD_T1_MS        32
`define SOWD_T2_MS        256
`define SOWD_T3_MS        1024

// bus clock overflow counts and window opening counts
`define SOWD_CNT_W        19
`define SOWD_BUS_T1_CYC   19'h0_2000
`define SOWD_BUS_T2_CYC   19'h1_0000
`define SOWD_BUS_T3_CYC   19'h4_0000
`define SOWD_BUS_W1_CYC   19'h0_1800
`define SOWD_BUS_W2_CYC   19'h0_c000
`define SOWD_BUS_W3_CYC   19'h3_0000
`define SOWD_CNT_ZERO     19'h0_0000
`define SOWD_CNT_ONE      19'h0_0001

// port bit positions
`define SOWD_PF_TX        0
`define SOWD_PF_RX        1
`define SOWD_PF_SCL       2
`define SOWD_PF_SDA       3
`define SOWD_PE_SCL       4
`define SOWD_PE_SDA       5
`define SOWD_PE_TX        6
`define SOWD_PE_RX        7

`endif

// *** sowd_top.v ***
// system options registers, stop-mode gate and watchdog top level
//
// Operation
// (RULE_01) only first options write after reset sticks
// (RULE_02) options register readable at any time
// (RULE_03) software should write options during initialisation
// (RULE_04) bits 7:6 select the watchdog timeout
// (RULE_05) low-power source gives 32ms, 256ms, 1.024s
// (RULE_06) bus clock gives 2^13, 2^16, 2^18 cycles
// (RULE_07) windowed clear legal only in last quarter
// (RULE_08) bit 5 allows stop, else illegal-opcode reset
// (RULE_09) bit 4 moves serial pins port f/e
// (RULE_10) bit 3 moves two-wire pins port f/e
// (RULE_11) bits 2:0 read zero; reset value 0xc0
// (RULE_12) overflow or early clear forces system reset
`timescale 1ns/1ps
`default_nettype none
`include "sowd_regs.vh"
module sowd_top #(
  // long counts stay parameters so a simulation can shorten them
  parameter [`SOWD_CNT_W-1:0] P_BUS_T1 = `SOWD_BUS_T1_CYC,
  parameter [`SOWD_CNT_W-1:0] P_BUS_T2 = `SOWD_BUS_T2_CYC,
  parameter [`SOWD_CNT_W-1:0] P_BUS_T3 = `SOWD_BUS_T3_CYC,
  parameter [`SOWD_CNT_W-1:0] P_BUS_W1 = `SOWD_BUS_W1_CYC,
  parameter [`SOWD_CNT_W-1:0] P_BUS_W2 = `SOWD_BUS_W2_CYC,
  parameter [`SOWD_CNT_W-1:0] P_BUS_W3 = `SOWD_BUS_W3_CYC
) (
  // clock, reset and freeze
  input  wire                    i_sys_clk,
  input  wire                    i_arst_n,
  input  wire                    i_clk_en,
  // register port
  input  wire [`SOWD_ADDR_W-1:0] i_addr,
  input  wire [`SOWD_DATA_W-1:0] i_wr_data,
  input  wire                    i_wr_en,
  input  wire                    i_rd_en,
  output reg  [`SOWD_DATA_W-1:0] o_rd_data,
  // low-power tick and processor stop request
  input  wire                    i_lpo_tick,
  input  wire                    i_stop_req,
  output reg                     o_stop_grant,
  output reg                     o_illegal_op_reset,
  output wire                    o_wdog_reset,
  // peripheral side of the routed units
  input  wire                    i_ser2_tx,
  input  wire                    i_scl_low,
  input  wire                    i_sda_low,
  output wire                    o_ser2_rx,
  output wire                    o_scl_in,
  output wire                    o_sda_in,
  // port pins
  input  wire [3:0]              i_port_f_in,
  input  wire [7:4]              i_port_e_in,
  output wire [3:0]              o_port_f_out,
  output wire [3:0]              o_port_f_oe,
  output wire [7:4]              o_port_e_out,
  output wire [7:4]              o_port_e_oe
);

  // register offset decode, used by the write strobes; the read path has its own case
  function hit;
    input [`SOWD_ADDR_W-1:0] addr;
    input [`SOWD_ADDR_W-1:0] ofs;
    begin
      hit = (addr == ofs);
    end
  endfunction

  // stored registers
  reg  [`SOWD_DATA_W-1:0] system_options_one; // write-once options
  reg  [`SOWD_DATA_W-1:0] system_options_two; // clock select, window
  reg                     opt1_locked;        // first write taken
  reg                     wd_clear;           // clear pulse to counter

  // decoded strobes
  wire                    wr_opt1;
  wire                    wr_opt2;
  wire                    wr_wdclr;

  // field views of the options
  wire [1:0]              watchdog_timeout_select;
  wire                    stop_mode_allow;
  wire                    serial2_pin_route;
  wire                    two_wire_pin_route;
  wire                    watchdog_clock_select;
  wire                    watchdog_window_enable;

  // watchdog state seen by software
  wire                    wd_running;
  wire                    wd_win_open;

  // read mux result
  reg  [`SOWD_DATA_W-1:0] next_rd_data;
  reg  [`SOWD_DATA_W-1:0] status;

  // strobes per register
  assign wr_opt1  = i_wr_en & hit(i_addr, `SOWD_OFS_OPT1);
  assign wr_opt2  = i_wr_en & hit(i_addr, `SOWD_OFS_OPT2);
  assign wr_wdclr = i_wr_en & hit(i_addr, `SOWD_OFS_WDCLR);

  // option fields
  assign watchdog_timeout_select =
    system_options_one[`SOWD_TSEL_HI:`SOWD_TSEL_LO];              // [RULE_04]
  assign stop_mode_allow    = system_options_one[`SOWD_STOPA_BIT];
  assign serial2_pin_route  = system_options_one[`SOWD_SER2_BIT];
  assign two_wire_pin_route = system_options_one[`SOWD_TWO_BIT];
  assign watchdog_clock_select =
    system_options_two[`SOWD_CLKSEL_BIT];
  assign watchdog_window_enable =
    system_options_two[`SOWD_WINEN_BIT];

  // write-once options register with its lock
  // software is expected to write it at start-up even with the reset
  // values, otherwise a stray write later could still change them
  // (RULE_03 binds software; the lock below is what makes it matter)
  always @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      system_options_one <= `SOWD_OPT1_RST;                       // [RULE_11]
      opt1_locked        <= 1'b0;
    end else if (i_clk_en) begin
      if (wr_opt1 && !opt1_locked) begin                          // [RULE_01]
        // unimplemented low bits never store
        system_options_one <= i_wr_data & `SOWD_OPT1_MASK;        // [RULE_11]
        opt1_locked        <= 1'b1;                               // [RULE_01]
      end
    end
  end

  // second options register, writable at any time
  // changing the clock source mid-count keeps the count; software
  // should clear the watchdog right after such a change
  always @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      system_options_two <= `SOWD_OPT2_RST;
    end else if (i_clk_en) begin
      if (wr_opt2) begin
        system_options_two <= i_wr_data & `SOWD_OPT2_MASK;
      end
    end
  end

  // any write to the clear offset is a service of the watchdog;
  // registered so the counter sees it one cycle after the write
  always @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      wd_clear <= 1'b0;
    end else if (i_clk_en) begin
      wd_clear <= wr_wdclr;                                       // [RULE_07]
    end
  end

  // status word built from live block state
  always @* begin
    status                = `SOWD_ZERO_BYTE;
    status[`SOWD_ST_LOCK] = opt1_locked;
    status[`SOWD_ST_RUN]  = wd_running;
    status[`SOWD_ST_WIN]  = wd_win_open;
  end

  // read mux; unmapped offsets and the clear offset read zero
  always @* begin
    next_rd_data = `SOWD_ZERO_BYTE;
    case (i_addr)
      `SOWD_OFS_OPT1: begin
        next_rd_data = system_options_one;                 // [RULE_02] [RULE_11]
      end
      `SOWD_OFS_OPT2: begin
        next_rd_data = system_options_two;
      end
      `SOWD_OFS_STAT: begin
        next_rd_data = status;
      end
      default: begin
        next_rd_data = `SOWD_ZERO_BYTE;
      end
    endcase
  end

  // read data stands only in the cycle after the read strobe
  always @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_rd_data <= `SOWD_ZERO_BYTE;
    end else if (i_clk_en) begin
      if (i_rd_en) begin
        o_rd_data <= next_rd_data;                                // [RULE_02]
      end else begin
        o_rd_data <= `SOWD_ZERO_BYTE;
      end
    end
  end

  // stop request gate: grant when allowed, else force the illegal
  // opcode reset; the selected one repeats the request level one cycle later
  always @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_stop_grant       <= 1'b0;
      o_illegal_op_reset <= 1'b0;
    end else if (i_clk_en) begin
      o_stop_grant       <= i_stop_req & stop_mode_allow;         // [RULE_08]
      o_illegal_op_reset <= i_stop_req & ~stop_mode_allow;        // [RULE_08]
    end
  end

  // watchdog counter; its fire pulse is the system reset request
  sowd_wdog #(
    .P_BUS_T1 (P_BUS_T1),
    .P_BUS_T2 (P_BUS_T2),
    .P_BUS_T3 (P_BUS_T3),
    .P_BUS_W1 (P_BUS_W1),
    .P_BUS_W2 (P_BUS_W2),
    .P_BUS_W3 (P_BUS_W3)
  ) u_wdog (
    .i_sys_clk  (i_sys_clk),
    .i_arst_n   (i_arst_n),
    .i_clk_en   (i_clk_en),
    .i_tsel     (watchdog_timeout_select),          // [RULE_04]
    .i_clk_sel  (watchdog_clock_select),            // [RULE_05] [RULE_06]
    .i_win_en   (watchdog_window_enable),           // [RULE_07]
    .i_lpo_tick (i_lpo_tick),
    .i_clear    (wd_clear),
    .o_fire     (o_wdog_reset),                     // [RULE_12]
    .o_running  (wd_running),
    .o_win_open (wd_win_open)
  );

  // pin routing; outputs there are flops, so these ports are too
  sowd_pin_route u_pins (
    .i_sys_clk    (i_sys_clk),
    .i_arst_n     (i_arst_n),
    .i_clk_en     (i_clk_en),
    .i_ser2_route (serial2_pin_route),              // [RULE_09]
    .i_two_route  (two_wire_pin_route),             // [RULE_10]
    .i_ser2_tx    (i_ser2_tx),
    .i_scl_low    (i_scl_low),
    .i_sda_low    (i_sda_low),
    .i_port_f_in  (i_port_f_in),
    .i_port_e_in  (i_port_e_in),
    .o_port_f_out (o_port_f_out),
    .o_port_f_oe  (o_port_f_oe),
    .o_port_e_out (o_port_e_out),
    .o_port_e_oe  (o_port_e_oe),
    .o_ser2_rx    (o_ser2_rx),
    .o_scl_in     (o_scl_in),
    .o_sda_in     (o_sda_in)
  );

endmodule // sowd_top
`default_nettype wire

// *** sowd_top_monitor.sv ***
// assertion checker for the options registers, stop gate and pin routing
`timescale 1ns/1ps
`default_nettype none
`include "sowd_regs.vh"
module sowd_top_monitor (
  input wire logic                    i_sys_clk,
  input wire logic                    i_arst_n,
  input wire logic                    i_clk_en,
  input wire logic [`SOWD_ADDR_W-1:0] i_addr,
  input wire logic [`SOWD_DATA_W-1:0] i_wr_data,
  input wire logic                    i_wr_en,
  input wire logic                    i_rd_en,
  input wire logic [`SOWD_DATA_W-1:0] o_rd_data,
  input wire logic                    i_stop_req,
  input wire logic                    o_stop_grant,
  input wire logic                    o_illegal_op_reset,
  input wire logic                    o_wdog_reset,
  input wire logic                    i_ser2_tx,
  input wire logic                    i_scl_low,
  input wire logic [3:0]              o_port_f_out,
  input wire logic [3:0]              o_port_f_oe,
  input wire logic [7:4]              o_port_e_oe
);
  logic [7:0] opt;  // shadow of options_one
  logic       lock; // first write seen
  wire        sa = opt[5]; // stop allow
  wire        r4 = opt[4]; // serial route
  wire        r3 = opt[3]; // two-wire route
  // shadow keeps only the first taken write, as the lock demands
  always @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      opt  <= `SOWD_OPT1_RST;
      lock <= 1'b0;
    end else if (i_clk_en && i_wr_en && !lock &&
                 i_addr == `SOWD_OFS_OPT1) begin
      opt  <= i_wr_data & `SOWD_OPT1_MASK;
      lock <= 1'b1;
    end
  end
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_arst_n);
  a_once_read: assert property (i_clk_en && i_rd_en &&
    i_addr == `SOWD_OFS_OPT1 |=> o_rd_data == opt) else $error("opt read");
  a_low_zero: assert property (i_clk_en && i_rd_en &&
    i_addr == `SOWD_OFS_OPT1 |=> o_rd_data[2:0] == 3'h0)
    else $error("low bits set");
  a_read_idle: assert property (i_clk_en && !i_rd_en |=>
    o_rd_data == `SOWD_ZERO_BYTE) else $error("idle read data");
  a_stop_gate: assert property (i_clk_en && i_stop_req |=>
    o_stop_grant == $past(sa) && o_illegal_op_reset == !$past(sa))
    else $error("stop gate");
  a_stop_cause: assert property (o_stop_grant || o_illegal_op_reset
    |-> $past(i_stop_req)) else $error("stop pulse uncaused");
  a_wdog_pulse: assert property (o_wdog_reset && i_clk_en
    |=> !o_wdog_reset) else $error("watchdog pulse long");
  // pins follow the options only from the first edge after release,
  // so the edge at which reset is still sampled low starts nothing
  a_ser_route: assert property (i_arst_n && i_clk_en &&
    $stable(r4) |=> o_port_e_oe[6] == $past(r4) &&
    o_port_f_oe[0] == !$past(r4)) else $error("serial route");
  a_tx_follow: assert property (i_arst_n && i_clk_en && !r4 &&
    $stable(r4) |=> o_port_f_out[0] == $past(i_ser2_tx))
    else $error("tx level");
  a_scl_route: assert property (i_arst_n && i_clk_en &&
    $stable(r3) |=>
    o_port_e_oe[4] == ($past(r3) & $past(i_scl_low)) &&
    o_port_f_oe[2] == (!$past(r3) & $past(i_scl_low)) &&
    o_port_f_out[2] == 1'b0) else $error("clock pin route");
  c_grant: cover property (o_stop_grant);
  c_illegal: cover property (o_illegal_op_reset);
  c_fire: cover property (o_wdog_reset);
endmodule // sowd_top_monitor

bind sowd_top sowd_top_monitor i_mon (
  .i_sys_clk(i_sys_clk), .i_arst_n(i_arst_n), .i_clk_en(i_clk_en),
  .i_addr(i_addr), .i_wr_data(i_wr_data), .i_wr_en(i_wr_en),
  .i_rd_en(i_rd_en), .o_rd_data(o_rd_data), .i_stop_req(i_stop_req),
  .o_stop_grant(o_stop_grant), .o_illegal_op_reset(o_illegal_op_reset),
  .o_wdog_reset(o_wdog_reset), .i_ser2_tx(i_ser2_tx),
  .i_scl_low(i_scl_low), .o_port_f_out(o_port_f_out),
  .o_port_f_oe(o_port_f_oe), .o_port_e_oe(o_port_e_oe)
);
`default_nettype wire

// *** sowd_top_tb.sv ***
// self-checking bench for the options registers and watchdog
`timescale 1ns/1ps
`default_nettype none
`include "sowd_regs.vh"
module sowd_top_tb;
  logic       i_sys_clk   = 1'b0;
  logic       i_arst_n    = 1'b0;
  logic       i_clk_en    = 1'b1; // freeze, dropped once per pass
  logic [2:0] i_addr      = 3'h0;
  logic [7:0] i_wr_data   = 8'h00;
  logic       i_wr_en     = 1'b0;
  logic       i_rd_en     = 1'b0;
  logic       i_lpo_tick  = 1'b0;
  logic       i_stop_req  = 1'b0;
  logic       i_ser2_tx   = 1'b1;
  logic       i_scl_low   = 1'b0;
  logic       i_sda_low   = 1'b0;
  logic [3:0] i_port_f_in = 4'hf;
  logic [7:4] i_port_e_in = 4'hf;
  logic [7:0] v;             // options_one value written
  logic [7:0] rn;            // random draw for pins
  wire  [7:0] o_rd_data;
  wire        o_stop_grant, o_illegal_op_reset, o_wdog_reset;
  wire        o_ser2_rx, o_scl_in, o_sda_in;
  wire  [3:0] o_port_f_out, o_port_f_oe;
  wire  [7:4] o_port_e_out, o_port_e_oe;
  integer     n_fail = 0, checks = 0, cyc = 0, seed = 32'h4d8a;
  integer     k, n, m;
  // model counts: bus overflow (first: span watched while disabled),
  // window opening, tick timeouts; the shortest bus pair is full size
  integer     nb[4] = '{64, 8192, 32, 64};
  integer     wb[4] = '{0, 6144, 24, 48};
  integer     nl[4] = '{0, 32, 256, 1024};

  // the shortest timeout runs at full size; the longer two are cut
  sowd_top #(.P_BUS_T2(19'h0_0020), .P_BUS_T3(19'h0_0040),
    .P_BUS_W2(19'h0_0018), .P_BUS_W3(19'h0_0030)) i_dut (
    .i_sys_clk(i_sys_clk), .i_arst_n(i_arst_n), .i_clk_en(i_clk_en),
    .i_addr(i_addr), .i_wr_data(i_wr_data), .i_wr_en(i_wr_en),
    .i_rd_en(i_rd_en), .o_rd_data(o_rd_data), .i_lpo_tick(i_lpo_tick),
    .i_stop_req(i_stop_req), .o_stop_grant(o_stop_grant),
    .o_illegal_op_reset(o_illegal_op_reset), .o_wdog_reset(o_wdog_reset),
    .i_ser2_tx(i_ser2_tx), .i_scl_low(i_scl_low), .i_sda_low(i_sda_low),
    .o_ser2_rx(o_ser2_rx), .o_scl_in(o_scl_in), .o_sda_in(o_sda_in),
    .i_port_f_in(i_port_f_in), .i_port_e_in(i_port_e_in),
    .o_port_f_out(o_port_f_out), .o_port_f_oe(o_port_f_oe),
    .o_port_e_out(o_port_e_out), .o_port_e_oe(o_port_e_oe));

  // 50 MHz clock
  always #10 i_sys_clk = ~i_sys_clk;
  // hang guard, about twice the full run
  always @(posedge i_sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      n_fail = n_fail + 1;
      give_verdict;
    end
  end
  // pins: driven level where enabled, random far-side level elsewhere
  always @(posedge i_sys_clk) begin
    rn = 8'($random(seed));
    {i_ser2_tx, i_scl_low, i_sda_low} <= rn[2:0];
    i_port_f_in <= (o_port_f_out & o_port_f_oe) | (rn[7:4] & ~o_port_f_oe);
    i_port_e_in <= (o_port_e_out & o_port_e_oe) | (rn[6:3] & ~o_port_e_oe);
  end

  task automatic tk;
    @(posedge i_sys_clk);
  endtask
  task automatic chk(input string nm, input logic [15:0] seen, exp);
    checks = checks + 1;
    if (seen !== exp) begin
      n_fail = n_fail + 1;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  // one-cycle write strobe
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    tk;
    i_addr <= a;
    i_wr_data <= d;
    i_wr_en <= 1'b1;
    tk;
    i_wr_en <= 1'b0;
  endtask
  // read strobe, data looked at in the following cycle only
  task automatic rd(input logic [2:0] a, input logic [7:0] e,
                    input string nm);
    tk;
    i_addr <= a;
    i_rd_en <= 1'b1;
    tk;
    i_rd_en <= 1'b0;
    #1 chk(nm, {8'h00, o_rd_data}, {8'h00, e});
  endtask
  task automatic rst;
    i_arst_n <= 1'b0;
    repeat (12) tk;
    i_arst_n <= 1'b1;
  endtask
  // wait for a watchdog pulse, n returns lim if none came
  task automatic wf(input integer lim, output integer c);
    c = 0;
    while (o_wdog_reset !== 1'b1 && c < lim) begin
      tk;
      #1 c = c + 1;
    end
  endtask
  // pin map against the levels the unit and the pins had at the edge
  task automatic pins(input logic r4, r3);
    logic [3:0] pf;
    logic [7:4] pe;
    logic       tx, sl, sd;
    tk;
    pf = i_port_f_in;
    pe = i_port_e_in;
    tx = i_ser2_tx;
    sl = i_scl_low;
    sd = i_sda_low;
    #1 chk("ser", {11'h0, o_ser2_rx, o_port_e_oe[6], o_port_f_oe[0],
      o_port_f_oe[1] | o_port_e_oe[7], r4 ? o_port_e_out[6] : o_port_f_out[0]},
      {11'h0, r4 ? pe[7] : pf[1], r4, !r4, 1'b0, tx});
    chk("twi", {8'h0, o_scl_in, o_port_e_oe[4], o_port_f_oe[2],
      o_port_e_out[4] | o_port_f_out[2], o_sda_in, o_port_e_oe[5],
      o_port_f_oe[3], o_port_e_out[5] | o_port_f_out[3]},
      {8'h0, r3 ? pe[4] : pf[2], r3 & sl, !r3 & sl, 1'b0,
      r3 ? pe[5] : pf[3], r3 & sd, !r3 & sd, 1'b0});
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // one pass per timeout code, each after a fresh reset
  initial begin
    for (k = 0; k < 4; k = k + 1) begin
      tk;
      rst;
      rd(3'h0, `SOWD_OPT1_RST, "rst");
      v = 8'($random(seed));
      v[7:6] = k[1:0];
      v[5] = k[0];
      v[4:3] = {k[1], ~k[0]};
      wr(3'h0, v);
      wr(3'h0, ~v);
      rd(3'h0, v & `SOWD_OPT1_MASK, "once");
      rd(3'h3, {5'h0, 1'b1, k != 0, 1'b1}, "stat");
      wr(3'h4 | 3'(k), 8'hff);
      rd(3'h4 | 3'(k), 8'h00, "gap");
      tk;
      i_stop_req <= 1'b1;
      tk;
      i_stop_req <= 1'b0;
      #1 chk("stop", {14'h0, o_stop_grant, o_illegal_op_reset},
        {14'h0, v[5], !v[5]});
      pins(v[4], v[3]);
      // bus clock overflow after a clear, none when disabled
      wr(3'h1, 8'h01);
      wr(3'h2, 8'h00);
      // freeze with the clear pending; a counter that ran on would fire
      // five cycles early and fall out of the window below
      i_clk_en <= 1'b0;
      repeat (5) tk;
      i_clk_en <= 1'b1;
      wf(nb[k] + 8, n);
      chk("ovf", {15'h0, k == 0 ? n == nb[0] + 8 :
        (n >= nb[k] - 1 && n <= nb[k] + 3)}, 16'h1);
      if (k > 0) begin
        // windowed: legal clear restarts, early clear fires
        wr(3'h1, 8'h03);
        wf(nb[k] + 8, n);
        repeat (wb[k]) tk;
        wr(3'h2, 8'h00);
        wf(wb[k] - 4, n);
        chk("legal", 16'(n), 16'(wb[k] - 4));
        wr(3'h2, 8'h00);
        wf(4, n);
        chk("early", {15'h0, n < 4}, 16'h1);
        // low-power ticks until the pulse
        wr(3'h1, 8'h00);
        wr(3'h2, 8'h00);
        m = 0;
        n = 0;
        while (n == 0 && m < nl[k] + 3) begin
          tk;
          i_lpo_tick <= 1'b1;
          m = m + 1;
          tk;
          i_lpo_tick <= 1'b0;
          #1 n = (o_wdog_reset === 1'b1);
          tk;
          #1 n = n | (o_wdog_reset === 1'b1);
        end
        chk("lpo", {15'h0, m >= nl[k] && m <= nl[k] + 1}, 16'h1);
      end
      $display("test %0d done", k);
    end
    give_verdict;
  end
endmodule // sowd_top_tb
`default_nettype wire

// *** sowd_wdog.v ***
// watchdog counter with selectable clock, timeout and window check
`timescale 1ns/1ps
`default_nettype none
`include "sowd_regs.vh"
module sowd_wdog #(
  parameter [`SOWD_CNT_W-1:0] P_BUS_T1 = `SOWD_BUS_T1_CYC,
  parameter [`SOWD_CNT_W-1:0] P_BUS_T2 = `SOWD_BUS_T2_CYC,
  parameter [`SOWD_CNT_W-1:0] P_BUS_T3 = `SOWD_BUS_T3_CYC,
  parameter [`SOWD_CNT_W-1:0] P_BUS_W1 = `SOWD_BUS_W1_CYC,
  parameter [`SOWD_CNT_W-1:0] P_BUS_W2 = `SOWD_BUS_W2_CYC,
  parameter [`SOWD_CNT_W-1:0] P_BUS_W3 = `SOWD_BUS_W3_CYC
) (
  input  wire       i_sys_clk,
  input  wire       i_arst_n,
  input  wire       i_clk_en,
  input  wire [1:0] i_tsel,      // timeout select code
  input  wire       i_clk_sel,   // 1 = bus clock, 0 = low-power tick
  input  wire       i_win_en,    // windowed mode
  input  wire       i_lpo_tick,  // one-cycle 1 kHz tick
  input  wire       i_clear,     // software clear pulse
  output reg        o_fire,      // one-cycle timeout pulse
  output wire       o_running,
  output wire       o_win_open
);
  // low-power counts derived from the printed times
  // reckoned as integers, then cut to the counter width on purpose
  localparam integer LPO_T1_I =
    (`SOWD_T1_MS * `SOWD_US_PER_MS) / `SOWD_LPO_PERIOD_US;
  localparam integer LPO_T2_I =
    (`SOWD_T2_MS * `SOWD_US_PER_MS) / `SOWD_LPO_PERIOD_US;
  localparam integer LPO_T3_I =
    (`SOWD_T3_MS * `SOWD_US_PER_MS) / `SOWD_LPO_PERIOD_US;
  localparam [`SOWD_CNT_W-1:0] LPO_T1 = LPO_T1_I[`SOWD_CNT_W-1:0];
  localparam [`SOWD_CNT_W-1:0] LPO_T2 = LPO_T2_I[`SOWD_CNT_W-1:0];
  localparam [`SOWD_CNT_W-1:0] LPO_T3 = LPO_T3_I[`SOWD_CNT_W-1:0];

  reg  [`SOWD_CNT_W-1:0] cnt;   // elapsed count since last clear
  wire [`SOWD_CNT_W-1:0] lim;   // selected overflow count
  wire [`SOWD_CNT_W-1:0] wopen; // first count at which a clear is legal
  wire                   adv;   // count advances this cycle
  wire                   early; // clear before the window opens

  // overflow count per clock source and select code
  assign lim = (i_tsel == `SOWD_TSEL_T1) ? (i_clk_sel ? P_BUS_T1 : LPO_T1) :
               (i_tsel == `SOWD_TSEL_T2) ? (i_clk_sel ? P_BUS_T2 : LPO_T2) :
                                           (i_clk_sel ? P_BUS_T3 : LPO_T3);
  assign wopen = (i_tsel == `SOWD_TSEL_T1) ? P_BUS_W1 :
                 (i_tsel == `SOWD_TSEL_T2) ? P_BUS_W2 : P_BUS_W3;
  assign o_running  = (i_tsel != `SOWD_TSEL_OFF);                 // [RULE_05]
  assign adv        = i_clk_sel | i_lpo_tick;               // [RULE_05] [RULE_06]
  // the window only exists on the bus clock source
  assign o_win_open = ~(i_win_en & i_clk_sel) | (cnt >= wopen);   // [RULE_07]
  assign early      = i_clear & ~o_win_open;                      // [RULE_12]

  // count, clear and timeout; the fire pulse restarts the count
  always @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      cnt    <= `SOWD_CNT_ZERO;
      o_fire <= 1'b0;
    end else if (i_clk_en) begin
      o_fire <= 1'b0;
      if (!o_running) begin
        cnt <= `SOWD_CNT_ZERO;
      end else if (i_clear) begin
        cnt    <= `SOWD_CNT_ZERO;
        o_fire <= early;                                          // [RULE_12]
      end else if (adv) begin
        if (cnt + `SOWD_CNT_ONE >= lim) begin
          cnt    <= `SOWD_CNT_ZERO;
          o_fire <= 1'b1;                                         // [RULE_12]
        end else begin
          cnt <= cnt + `SOWD_CNT_ONE;
        end
      end
    end
  end
endmodule // sowd_wdog
`default_nettype wire
